//--- hw/usbif_pkg.sv
// Package for the USB interface flag and PHY control register block.
// Assumes a single 100 MHz clock and a simple strobe register port.
package usbif_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_STICKY  = 8'h20;
	localparam logic [7:0] OFS_MASKS   = 8'h24;
	localparam logic [7:0] OFS_SOF     = 8'h28;
	localparam logic [7:0] OFS_PID     = 8'h2c;
	localparam logic [7:0] OFS_EP      = 8'h30;
	localparam logic [7:0] OFS_EPMARK  = 8'h34;
	localparam logic [7:0] OFS_OTGMSK  = 8'h38;
	localparam logic [7:0] OFS_PWRSIG  = 8'h3c;
	localparam logic [7:0] OFS_PHYCTL  = 8'h40;
	localparam logic [7:0] OFS_FLAGS   = 8'h1c;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h44;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h48;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h4c;

	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int NFLAG          = 7;
	localparam int FLG_RXERR      = 0;
	localparam int FLG_RXACT      = 1;
	localparam int FLG_CRC16      = 2;
	localparam int FLG_J          = 3;
	localparam int FLG_K          = 4;
	localparam int FLG_SE0        = 5;
	localparam int FLG_TOKEN      = 6;
	localparam int EP_VALID_BIT   = 4;
	localparam int PHY_PD_DIS     = 18;
	localparam int PHY_RES_SE0    = 13;
	localparam int PHY_RES_K      = 12;
	localparam int PHY_FILT_HI    = 11;
	localparam int PHY_FILT_LO    = 8;
	localparam int PHY_SUSP_EN    = 7;
	localparam int PHY_CONF_HI    = 6;
	localparam int PHY_CONF_LO    = 4;
	localparam int NIRQ           = 3;
	localparam int IRQ_TOKEN      = 0;
	localparam int IRQ_RESUME     = 1;
	localparam int IRQ_LS_CHANGE  = 2;

	// ----------------------------------------
	// Reset values and linestate codes
	// ----------------------------------------
	localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
	localparam logic [1:0]  LS_SE0       = 2'h0;
	localparam logic [1:0]  LS_J         = 2'h1;
	localparam logic [1:0]  LS_K         = 2'h2;
	localparam logic [4:0]  EP_MARK_BIT  = 5'h10;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} usbif_bus_s;

	typedef struct packed {
		logic       pkt_start;
		logic       rx_error;
		logic       rx_active;
		logic       crc16_fail;
		logic       token_ok;
		logic       pid_valid;
		logic [3:0] pid;
		logic       ep_valid;
		logic [3:0] ep;
		logic       sof_valid;
		logic [10:0] sof;
		logic       auto_resume;
	} usbif_pkt_s;

	typedef enum logic [1:0] {
		LS_IDLE,
		LS_WAIT
	} usbif_ls_e;

endpackage : usbif_pkg

//--- hw/usbif_ls_filter.sv
// Linestate change filter: a new line state passes after 2**n stable clocks.
// Assumes the raw line state is already synchronised to CLK_SYS.
`timescale 1ns/10ps
module usbif_ls_filter
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic [3:0] log2_len,
	// Line state
	input  wire logic [1:0] ls_in,
	output logic      [1:0] ls_out,
	output logic            ls_chg
);

	usbif_pkg::usbif_ls_e state_r;
	logic [15:0]          cnt_r;
	logic [1:0]           cand_r;
	logic [15:0]          limit;

	assign limit = 16'(({1'b0, 16'h0001} << log2_len) - 17'd1);

	// ----------------------------------------
	// Filter state machine
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		ls_chg <= 1'b0;
		if (!rst_n)
		begin
			state_r <= usbif_pkg::LS_IDLE;
			cnt_r   <= 16'h0000;
			cand_r  <= usbif_pkg::LS_SE0;
			ls_out  <= usbif_pkg::LS_SE0;
		end
		else
		begin
			case (state_r)
				usbif_pkg::LS_IDLE:
				begin
					if (ls_in != ls_out)
					begin
						cand_r  <= ls_in;
						cnt_r   <= 16'h0000;
						state_r <= usbif_pkg::LS_WAIT;
					end
				end
				usbif_pkg::LS_WAIT:
				begin
					if (ls_in != cand_r)
						state_r <= usbif_pkg::LS_IDLE;
					else if (cnt_r == limit)
					begin
						// Change propagates after 2**n clocks
						ls_out  <= cand_r;
						ls_chg  <= 1'b1;
						state_r <= usbif_pkg::LS_IDLE;
					end
					else
						cnt_r <= cnt_r + 16'h0001;
				end
				default: state_r <= usbif_pkg::LS_IDLE;
			endcase
		end
	end

	a_filter_delay: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == usbif_pkg::LS_IDLE && ls_in != ls_out && log2_len == 4'h0)
		##1 (ls_in == cand_r) |=> ls_chg)
		else $error("linestate change not propagated after one clock");

endmodule : usbif_ls_filter

//--- hw/usbif_regs.sv
// USB interface flag, event port, frame/packet capture and PHY control registers.
// Assumes packet events come from a receive engine on CLK_SYS; line pins are raw.
// How it works
// - Sticky flags hold their value once set
// - Sticky flag clears on writing one
// - Non-sticky flags 0,1,3-5 follow later signal changes; flags 2 and 6 hold until packet start
// - Event ports N,O,P OR masked flags
// - Fourth event port ORs flags under top mask
// - Eleven-bit writable SOF counter, single field
// - Capture last received PID, read only
// - Capture last token endpoint, read only
// - Endpoint valid bit set on capture
// - Marked endpoints shown ORed with 0x10
// - Bit 18 disables data port pulldowns
// - Auto-resume by SE0 sets bit 13
// - Auto-resume by K sets bit 12
// - Linestate change delayed 2**n clocks
// - Bit 7 enables suspend controller resume
// - PHY config pins driven from bits 6:4
// - Non-sticky flags 0 and 1 clear at packet start
// - Flag 6 set on good token
`timescale 1ns/10ps
module usbif_regs
(
	// Clock and reset
	input  wire logic                  CLK_SYS,
	input  wire logic                  RSTN,
	// Register port
	input  wire usbif_pkg::usbif_bus_s BUS,
	output logic [31:0]                RDATA,
	// Receive engine events
	input  wire usbif_pkg::usbif_pkt_s PKT,
	// PHY pins
	input  wire logic [1:0]            LINESTATE,
	output logic [2:0]                 PHY_CONF,
	output logic                       PULLDOWN_DIS,
	output logic                       SUSPEND_RESUME_EN,
	// Event ports and receive port
	output logic                       EVENT_N,
	output logic                       EVENT_O,
	output logic                       EVENT_P,
	output logic                       EVENT_Q,
	output logic [4:0]                 RX_EP,
	output logic                       RX_EP_VALID,
	// Interrupt
	output logic                       IRQ
);

	logic [6:0]  flags_r;
	logic [6:0]  flags_nxt;
	logic [6:0]  sticky_r;
	logic [31:0] masks_r;
	logic [10:0] sof_r;
	logic [3:0]  pid_r;
	logic [3:0]  ep_r;
	logic        ep_valid_r;
	logic [15:0] epmark_r;
	logic [31:0] otgmsk_r;
	logic [8:0]  pwrsig_r;
	logic        pd_dis_r;
	logic        res_se0_r;
	logic        res_k_r;
	logic [3:0]  filt_r;
	logic        susp_en_r;
	logic [2:0]  conf_r;
	logic [2:0]  irq_st_r;
	logic [2:0]  irq_en_r;
	logic [1:0]  ls_s1_r;
	logic [1:0]  ls_s2_r;
	logic [1:0]  ls_filt;
	logic        ls_chg;
	logic [6:0]  flag_src;
	logic [6:0]  flag_clr;
	logic        wr_flags;
	logic        wr_sticky;

	assign wr_flags  = BUS.wr && BUS.addr == usbif_pkg::OFS_FLAGS;
	assign wr_sticky = BUS.wr && BUS.addr == usbif_pkg::OFS_STICKY;

	// ----------------------------------------
	// Line state synchroniser and filter
	// ----------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			ls_s1_r <= usbif_pkg::LS_SE0;
			ls_s2_r <= usbif_pkg::LS_SE0;
		end
		else
		begin
			ls_s1_r <= LINESTATE;
			ls_s2_r <= ls_s1_r;
		end
	end

	usbif_ls_filter u_filter
	(
		.clk      (CLK_SYS),
		.rst_n    (RSTN),
		.log2_len (filt_r),
		.ls_in    (ls_s2_r),
		.ls_out   (ls_filt),
		.ls_chg   (ls_chg)
	);

	// ----------------------------------------
	// Signal flags
	// ----------------------------------------
	always_comb
	begin
		flag_src                       = 7'h00;
		flag_src[usbif_pkg::FLG_RXERR] = PKT.rx_error;
		flag_src[usbif_pkg::FLG_RXACT] = PKT.rx_active;
		flag_src[usbif_pkg::FLG_CRC16] = PKT.crc16_fail;
		flag_src[usbif_pkg::FLG_J]     = ls_filt == usbif_pkg::LS_J;
		flag_src[usbif_pkg::FLG_K]     = ls_filt == usbif_pkg::LS_K;
		flag_src[usbif_pkg::FLG_SE0]   = ls_filt == usbif_pkg::LS_SE0;
		flag_src[usbif_pkg::FLG_TOKEN] = PKT.token_ok;
		flag_clr = wr_flags ? BUS.wdata[6:0] : 7'h00;
	end

	// One bit per flag, sticky bit i governs flag i
	always_comb
	begin
		for (int i = 0; i < usbif_pkg::NFLAG; i++)
		begin
			if (sticky_r[i])
				// Set beats the write-one clear
				flags_nxt[i] = flag_src[i] | (flags_r[i] & ~flag_clr[i]);
			else if (PKT.pkt_start)
				flags_nxt[i] = flag_src[i] & (i > usbif_pkg::FLG_RXACT);
			else if (i == usbif_pkg::FLG_TOKEN || i == usbif_pkg::FLG_CRC16)
				flags_nxt[i] = flags_r[i] | flag_src[i];
			else
				flags_nxt[i] = flag_src[i];
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
			flags_r <= 7'h00;
		else
			flags_r <= flags_nxt;
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			sticky_r  <= 7'h00;
			masks_r   <= usbif_pkg::RST_ZERO;
			epmark_r  <= 16'h0000;
			otgmsk_r  <= usbif_pkg::RST_ZERO;
			pwrsig_r  <= 9'h000;
			pd_dis_r  <= 1'b0;
			filt_r    <= 4'h0;
			susp_en_r <= 1'b0;
			conf_r    <= 3'h0;
			irq_en_r  <= 3'h0;
		end
		else if (BUS.wr)
		begin
			case (BUS.addr)
				usbif_pkg::OFS_STICKY:  sticky_r <= BUS.wdata[6:0];
				usbif_pkg::OFS_MASKS:   masks_r  <= BUS.wdata;
				usbif_pkg::OFS_EPMARK:  epmark_r <= BUS.wdata[15:0];
				usbif_pkg::OFS_OTGMSK:  otgmsk_r <= BUS.wdata;
				usbif_pkg::OFS_PWRSIG:  pwrsig_r <= BUS.wdata[8:0];
				usbif_pkg::OFS_IRQ_EN:  irq_en_r <= BUS.wdata[2:0];
				usbif_pkg::OFS_PHYCTL:
				begin
					pd_dis_r  <= BUS.wdata[usbif_pkg::PHY_PD_DIS];
					filt_r    <= BUS.wdata[usbif_pkg::PHY_FILT_HI:usbif_pkg::PHY_FILT_LO];
					susp_en_r <= BUS.wdata[usbif_pkg::PHY_SUSP_EN];
					conf_r    <= BUS.wdata[usbif_pkg::PHY_CONF_HI:usbif_pkg::PHY_CONF_LO];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Start-of-frame counter
	// ----------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
			sof_r <= 11'h000;
		else if (PKT.sof_valid)
			sof_r <= PKT.sof;
		else if (BUS.wr && BUS.addr == usbif_pkg::OFS_SOF)
			sof_r <= BUS.wdata[10:0];
	end

	// ----------------------------------------
	// PID and endpoint capture
	// ----------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			pid_r      <= 4'h0;
			ep_r       <= 4'h0;
			ep_valid_r <= 1'b0;
		end
		else
		begin
			if (PKT.pid_valid)
				pid_r <= PKT.pid;
			if (PKT.ep_valid)
			begin
				ep_r       <= PKT.ep;
				ep_valid_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Auto-resume cause flags
	// ----------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			res_se0_r <= 1'b0;
			res_k_r   <= 1'b0;
		end
		else
		begin
			// Resume cause set beats a software clear
			if (susp_en_r && PKT.auto_resume && ls_filt == usbif_pkg::LS_SE0)
				res_se0_r <= 1'b1;
			else if (BUS.wr && BUS.addr == usbif_pkg::OFS_PHYCTL
				&& !BUS.wdata[usbif_pkg::PHY_RES_SE0])
				res_se0_r <= 1'b0;
			if (susp_en_r && PKT.auto_resume && ls_filt == usbif_pkg::LS_K)
				res_k_r <= 1'b1;
			else if (BUS.wr && BUS.addr == usbif_pkg::OFS_PHYCTL
				&& !BUS.wdata[usbif_pkg::PHY_RES_K])
				res_k_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
			irq_st_r <= 3'h0;
		else
		begin
			for (int i = 0; i < usbif_pkg::NIRQ; i++)
			begin
				if (BUS.wr && BUS.addr == usbif_pkg::OFS_IRQ_CLR && BUS.wdata[i])
					irq_st_r[i] <= 1'b0;
			end
			if (PKT.token_ok)
				irq_st_r[usbif_pkg::IRQ_TOKEN] <= 1'b1;
			if (susp_en_r && PKT.auto_resume)
				irq_st_r[usbif_pkg::IRQ_RESUME] <= 1'b1;
			if (ls_chg)
				irq_st_r[usbif_pkg::IRQ_LS_CHANGE] <= 1'b1;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			EVENT_N           <= 1'b0;
			EVENT_O           <= 1'b0;
			EVENT_P           <= 1'b0;
			EVENT_Q           <= 1'b0;
			RX_EP             <= 5'h00;
			RX_EP_VALID       <= 1'b0;
			PHY_CONF          <= 3'h0;
			PULLDOWN_DIS      <= 1'b0;
			SUSPEND_RESUME_EN <= 1'b0;
			IRQ               <= 1'b0;
		end
		else
		begin
			EVENT_N           <= |(flags_r & masks_r[6:0]);
			EVENT_O           <= |(flags_r & masks_r[14:8]);
			EVENT_P           <= |(flags_r & masks_r[22:16]);
			EVENT_Q           <= |(flags_r & masks_r[30:24]);
			RX_EP_VALID       <= ep_valid_r;
			RX_EP             <= epmark_r[ep_r] ? ({1'b0, ep_r} | usbif_pkg::EP_MARK_BIT)
			                                    : {1'b0, ep_r};
			PHY_CONF          <= conf_r;
			PULLDOWN_DIS      <= pd_dis_r;
			SUSPEND_RESUME_EN <= susp_en_r;
			IRQ               <= |(irq_st_r & irq_en_r);
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
			RDATA <= usbif_pkg::RST_ZERO;
		else if (BUS.rd)
		begin
			case (BUS.addr)
				usbif_pkg::OFS_FLAGS:   RDATA <= {25'h0, flags_r};
				usbif_pkg::OFS_STICKY:  RDATA <= {25'h0, sticky_r};
				usbif_pkg::OFS_MASKS:   RDATA <= masks_r;
				usbif_pkg::OFS_SOF:     RDATA <= {21'h0, sof_r};
				usbif_pkg::OFS_PID:     RDATA <= {28'h0, pid_r};
				usbif_pkg::OFS_EP:      RDATA <= {27'h0, ep_valid_r, ep_r};
				usbif_pkg::OFS_EPMARK:  RDATA <= {16'h0, epmark_r};
				usbif_pkg::OFS_OTGMSK:  RDATA <= otgmsk_r;
				usbif_pkg::OFS_PWRSIG:  RDATA <= {23'h0, pwrsig_r};
				usbif_pkg::OFS_PHYCTL:  RDATA <= {13'h0, pd_dis_r, 4'h0, res_se0_r, res_k_r,
				                                  filt_r, susp_en_r, conf_r, 4'h0};
				usbif_pkg::OFS_IRQ_ST:  RDATA <= {29'h0, irq_st_r};
				usbif_pkg::OFS_IRQ_EN:  RDATA <= {29'h0, irq_en_r};
				default:                RDATA <= usbif_pkg::RST_ZERO;
			endcase
		end
		else
			RDATA <= usbif_pkg::RST_ZERO;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_sticky_hold: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!wr_flags |=> &(flags_r | ~$past(sticky_r & flags_r)))
		else $error("sticky flag lost its value");
	a_sticky_clear: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		(sticky_r[2] && wr_flags && BUS.wdata[2] && !PKT.crc16_fail) |=> !flags_r[2])
		else $error("sticky flag not cleared by write one");
	a_nonsticky_follow: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		(!sticky_r[1] && !PKT.pkt_start) |=> flags_r[1] == $past(PKT.rx_active))
		else $error("non-sticky flag did not follow signal");
	a_event_port_n: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		##1 EVENT_N == |($past(flags_r) & $past(masks_r[6:0])))
		else $error("event port N wrong");
	a_event_port_q: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		##1 EVENT_Q == |($past(flags_r) & $past(masks_r[30:24])))
		else $error("fourth event port wrong");
	a_pid_capture: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		PKT.pid_valid |=> pid_r == $past(PKT.pid))
		else $error("pid not captured");
	a_ep_valid: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		PKT.ep_valid |=> ep_valid_r ##1 RX_EP_VALID)
		else $error("endpoint valid not set");
	a_token_flag: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		PKT.token_ok |=> flags_r[usbif_pkg::FLG_TOKEN])
		else $error("token flag not set");
	a_conf_pins: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		(BUS.wr && BUS.addr == usbif_pkg::OFS_PHYCTL) |=> ##1 PHY_CONF == $past(BUS.wdata[6:4], 2))
		else $error("phy config pins not driven");

	c_sticky_clear: cover property (@(posedge CLK_SYS) sticky_r[2] && flags_r[2] ##1 wr_flags);
	c_event_n:      cover property (@(posedge CLK_SYS) EVENT_N);
	c_resume_k:     cover property (@(posedge CLK_SYS) res_k_r);
	c_irq:          cover property (@(posedge CLK_SYS) IRQ);

endmodule : usbif_regs

//--- sim/usbif_rx_model.sv
// Stand-in for the receive engine and the PHY line state pins.
// Assumes its tasks are called from the bench just after a rising clk edge.
`timescale 1ns/10ps
module usbif_rx_model
(
	// Clock
	input  wire logic             clk,
	// Far side outputs
	output usbif_pkg::usbif_pkt_s pkt,
	output logic [1:0]            ls
);
	initial
	begin
		pkt = '0;
		ls  = usbif_pkg::LS_J;
	end

	// ----------------------------------------
	// Event for one cycle, then inverted data fields; rx_error and rx_active kept
	// ----------------------------------------
	task automatic send(input usbif_pkg::usbif_pkt_s p);
		@(posedge clk);
		pkt <= p;
		@(posedge clk);
		pkt <= '{rx_error: p.rx_error, rx_active: p.rx_active, pid: ~p.pid, ep: ~p.ep,
			sof: ~p.sof, default: 1'b0};
	endtask : send

	// ----------------------------------------
	// Raw line level, resume only from K or SE0
	// ----------------------------------------
	task automatic line(input logic [1:0] v);
		@(posedge clk);
		ls <= v;
	endtask : line
endmodule : usbif_rx_model

//--- sim/test_usbif_regs.sv
// Self-checking bench for the flag, capture and PHY control registers.
// Assumes the design reads registers back one cycle after the read strobe.
`timescale 1ns/10ps
module test_usbif_regs;
	typedef struct packed {logic [31:0] e; logic [31:0] m;} usbif_exp_s;
	logic                  CLK_SYS;
	logic                  RSTN;
	usbif_pkg::usbif_bus_s BUS;
	logic [31:0]           RDATA;
	usbif_pkg::usbif_pkt_s PKT;
	logic [1:0]            LINESTATE;
	logic [2:0]            PHY_CONF;
	logic                  PULLDOWN_DIS, SUSPEND_RESUME_EN, EVENT_N, EVENT_O, EVENT_P, EVENT_Q;
	logic [4:0]            RX_EP;
	logic                  RX_EP_VALID, IRQ;
	logic                  rd_q = 1'b0;
	usbif_exp_s            q[$];
	usbif_exp_s            x;
	usbif_pkg::usbif_pkt_s p;
	int                    fails, n_tests, cnt;
	logic [31:0]           v;
	logic [7:0]            zo [10] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c,
		8'h40, 8'h4c};
	logic [7:0]            ro [3] = '{8'h2c, 8'h30, 8'h50};
	logic [7:0]            rw_a [7] = '{8'h20, 8'h24, 8'h28, 8'h34, 8'h38, 8'h3c, 8'h40};
	logic [31:0]           rw_m [7] = '{32'h0000_007f, 32'h7f7f_7f7f, 32'h0000_07ff,
		32'h0000_ffff, 32'hffff_ffff, 32'h0000_01ff, 32'h0004_0ff0};

	usbif_regs uut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .BUS(BUS), .RDATA(RDATA), .PKT(PKT),
		.LINESTATE(LINESTATE), .PHY_CONF(PHY_CONF), .PULLDOWN_DIS(PULLDOWN_DIS),
		.SUSPEND_RESUME_EN(SUSPEND_RESUME_EN), .EVENT_N(EVENT_N), .EVENT_O(EVENT_O),
		.EVENT_P(EVENT_P), .EVENT_Q(EVENT_Q), .RX_EP(RX_EP), .RX_EP_VALID(RX_EP_VALID),
		.IRQ(IRQ));
	usbif_rx_model rx (.clk(CLK_SYS), .pkt(PKT), .ls(LINESTATE));

	initial
	begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge CLK_SYS);
		BUS.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		@(posedge CLK_SYS);
		BUS <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		q.push_back('{e: e & m, m: m});
		@(posedge CLK_SYS);
		BUS.rd <= 1'b0;
	endtask : rd

	task automatic wait_irq(input int lim, output int c);
		c = 0;
		while (IRQ !== 1'b1 && c < lim)
		begin
			tick(1);
			c++;
		end
		if (c >= lim)
		begin
			$display("Error IRQ wait expected 1 seen %b", IRQ);
			fails++;
			wrap_up();
		end
	endtask : wait_irq

	task automatic pulse(input int b);
		p = '0;
		p[b] = 1'b1;
		rx.send(p);
	endtask : pulse

	// ----------------------------------------
	// Read data monitor
	// ----------------------------------------
	always @(posedge CLK_SYS)
	begin
		if (rd_q === 1'b1)
		begin
			x = q.pop_front();
			chk("RDATA", x.e, RDATA & x.m);
		end
		rd_q <= BUS.rd;
	end

	initial
	begin
		repeat (50000) @(posedge CLK_SYS);
		fails++;
		wrap_up();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		fails = 0;
		n_tests = 0;
		BUS = '0;
		RSTN = 1'b0;
		v = $urandom(24);
		repeat (20) @(posedge CLK_SYS);
		RSTN <= 1'b1;
		tick(1);
		chk("PINS", 32'h0, {EVENT_Q, EVENT_P, EVENT_O, EVENT_N, PHY_CONF, RX_EP_VALID, IRQ});
		foreach (zo[i]) rd(zo[i], 32'h0);
		foreach (ro[i])
		begin
			wr(ro[i], 32'hffff_ffff);
			rd(ro[i], 32'h0);
		end
		$display("Test reset finished");
		for (int i = 0; i < 7; i++)
		begin
			v = $urandom;
			wr(rw_a[i], v);
			rd(rw_a[i], v, rw_m[i]);
			wr(rw_a[i], 32'h0);
		end
		wr(8'h40, 32'h0004_04d0);
		tick(2);
		chk("PHYPINS", 32'h17, {PHY_CONF, PULLDOWN_DIS, SUSPEND_RESUME_EN});
		$display("Test access finished");
		tick(10);
		wr(8'h48, 32'h0000_0007);
		wr(8'h4c, 32'h0000_0004);
		rx.line(usbif_pkg::LS_K);
		wait_irq(40, cnt);
		chk("LSDELAY", 32'h1, cnt >= 16 && cnt <= 24);
		rd(8'h1c, 32'h0000_0010, 32'h0000_0038);
		pulse(0);
		rd(8'h40, 32'h0004_14d0);
		wr(8'h40, 32'h0004_24d0);
		rd(8'h40, 32'h0004_04d0);
		rx.line(usbif_pkg::LS_SE0);
		tick(30);
		pulse(0);
		rd(8'h40, 32'h0004_24d0);
		wr(8'h40, 32'h0004_04d0);
		rd(8'h40, 32'h0004_04d0);
		$display("Test linestate finished");
		wr(8'h48, 32'h0000_0007);
		wr(8'h4c, 32'h0000_0001);
		pulse(23);
		wait_irq(10, cnt);
		rd(8'h44, 32'h1, 32'h1);
		rd(8'h1c, 32'h40, 32'h40);
		wr(8'h4c, 32'h0);
		tick(2);
		chk("IRQ", 32'h0, IRQ);
		wr(8'h4c, 32'h1);
		tick(2);
		chk("IRQ", 32'h1, IRQ);
		wr(8'h48, 32'h1);
		tick(2);
		chk("IRQ", 32'h0, IRQ);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h24, 32'h40 << (8 * i));
			tick(3);
			chk("EVENTS", 32'h1 << i, {EVENT_Q, EVENT_P, EVENT_O, EVENT_N});
		end
		wr(8'h24, 32'h0404_0404);
		tick(3);
		chk("EVENTS", 32'h0, {EVENT_Q, EVENT_P, EVENT_O, EVENT_N});
		$display("Test events finished");
		pulse(24);
		rd(8'h1c, 32'h04, 32'h04);
		pulse(27);
		rd(8'h1c, 32'h00, 32'h44);
		wr(8'h20, 32'h45);
		p = '0;
		p.crc16_fail = 1'b1;
		p.token_ok = 1'b1;
		p.rx_error = 1'b1;
		rx.send(p);
		pulse(27);
		rd(8'h1c, 32'h45, 32'h47);
		wr(8'h1c, 32'h04);
		rd(8'h1c, 32'h41, 32'h47);
		wr(8'h20, 32'h0);
		pulse(26);
		rd(8'h1c, 32'h1, 32'h1);
		rx.send('0);
		rd(8'h1c, 32'h0, 32'h1);
		$display("Test sticky finished");
		wr(8'h34, 32'h0000_0020);
		p = '0;
		p.pid_valid = 1'b1;
		p.pid = 4'ha;
		p.ep_valid = 1'b1;
		p.ep = 4'h5;
		p.sof_valid = 1'b1;
		p.sof = 11'h5a3;
		rx.send(p);
		rd(8'h2c, 32'h0a);
		rd(8'h30, 32'h15);
		rd(8'h28, 32'h5a3);
		tick(1);
		chk("RX_EP", 32'h15, RX_EP);
		chk("RX_EP_VALID", 32'h1, RX_EP_VALID);
		p.ep = 4'h3;
		rx.send(p);
		tick(2);
		chk("RX_EP", 32'h03, RX_EP);
		$display("Test capture finished");
		tick(3);
		wrap_up();
	end
endmodule : test_usbif_regs
